// [pkg/sss_pkg.sv]
/*
  Constants and types shared by the soft-start sequencer design files.
  Assumes a single 50 MHz clock; analog levels arrive as digitised codes.
*/
package sss_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int unsigned CLK_HZ         = 50000000;
  localparam int unsigned SS_TIME_US     = 2000;
  localparam int unsigned SS_STEPS       = 15;
  localparam int unsigned SS_TIME_CYC    = SS_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned STEP_CYC       = SS_TIME_CYC / SS_STEPS;
  localparam int unsigned FAULT_RETRY_US = 8000;
  localparam int unsigned FAULT_RETRY_CYC =
    FAULT_RETRY_US * (CLK_HZ / 1000000);

  // ==========================================================
  // Reference codes (sense differential, 1 LSB = 0.5 mV)
  // ==========================================================
  localparam int unsigned REF_W        = 10;
  localparam logic [9:0]  REF_FULL     = 10'h12C;  // 150 mV
  localparam logic [9:0]  EXT_FLOOR    = 10'h03F;  // 31.5 mV
  localparam int unsigned HIGH_EXT_STEPS = 3;
  localparam logic [3:0]  STEP_RST     = 4'h0;

  // ==========================================================
  // Channel sequencing states
  // ==========================================================
  typedef enum logic [3:0] {
    SSS_IDLE = 4'b0001,
    SSS_RAMP = 4'b0010,
    SSS_RUN  = 4'b0100,
    SSS_WAIT = 4'b1000
  } sss_state_t;

endpackage : sss_pkg

// [design/sss_sync.sv]
/*
  Two-flop synchroniser for a bus of asynchronous levels.
  Assumes the inputs are quasi-static compared with the clock.
*/
module sss_sync
  import sss_pkg::*;
#(
  parameter int unsigned W = 1
)(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // ==========================================================
  // Two stages; first stage feeds only the second
  // ==========================================================
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : sss_sync

// [design/sss_channel.sv]
/*
  One channel of the soft-start sequencer: ramp stepping, restart
  handling, ON time extension and loop selection.
  Assumes synchronised inputs; the step tick is generated inside from STEP_LEN.
*/
module sss_channel
  import sss_pkg::*;
#(
  parameter int unsigned SS_CYC    = SS_TIME_CYC,
  parameter int unsigned STEP_LEN  = STEP_CYC,
  parameter int unsigned RETRY_CYC = FAULT_RETRY_CYC
)(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            dim_on,
  input  wire logic            restart,
  input  wire logic            short_fault,
  input  wire logic            adj_en,
  input  wire logic [REF_W-1:0] adj_ref,
  input  wire logic [REF_W-1:0] sense_diff,
  input  wire logic            vloop_en,
  input  wire logic            vfb_at_ref,
  output logic [REF_W-1:0]     ref_r,
  output logic [REF_W-1:0]     ext_thr_r,
  output logic                 ext_active_r,
  output logic                 gate_en_r,
  output logic                 ss_busy_r,
  output logic                 vloop_sel_r
);

  sss_state_t       state_r;
  logic             dim_d_r;
  logic [3:0]       step_r;
  logic [31:0]      tick_r;
  logic [31:0]      ss_cnt_r;
  logic [31:0]      retry_r;
  logic [31:0]      pulse_r;
  logic             armed_r;
  logic             ss_done;
  logic             step_tick;
  logic             retry_tick;
  logic             rise;
  logic             fall;
  logic [REF_W-1:0] target;
  logic [REF_W-1:0] ramp_ref;
  logic [REF_W-1:0] ext_nxt;
  logic [REF_W+3:0] prod;

  assign rise = dim_on & ~dim_d_r;
  assign fall = ~dim_on & dim_d_r;
  assign target = adj_en ? adj_ref : REF_FULL;
  assign ss_done = (ss_cnt_r >= SS_CYC);
  // Steps advance only while dimming ON or extending
  assign step_tick = (tick_r == STEP_LEN - 1) & (dim_on | ext_active_r);
  assign retry_tick = (retry_r == RETRY_CYC - 1);
  assign prod = REF_FULL * step_r;

  // Ramp value: equal steps of full scale, clamped at target
  always_comb
  begin
    ramp_ref = REF_W'(prod / SS_STEPS);                  // [RULE5]
    if (ramp_ref > target)
      ramp_ref = target;                                 // [RULE6]
  end

  // Extension threshold: 0.8 of the target reference, floored
  always_comb
  begin
    ext_nxt = REF_W'((32'(target) * 4) / 5);
    // Early steps: keep the threshold strictly above the ramp
    if (step_r < 4'(HIGH_EXT_STEPS) && ext_nxt <= ramp_ref)
      ext_nxt = ramp_ref + 10'h001;                      // [RULE10]
    if (ext_nxt < EXT_FLOOR)
      ext_nxt = EXT_FLOOR;                               // [RULE9]
  end

  // ==========================================================
  // Edge tracking and arming
  // ==========================================================
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dim_d_r <= 1'b0;
      armed_r <= 1'b0;
    end
    else
    begin
      dim_d_r <= dim_on;
      if (rise)
        armed_r <= 1'b1;                                 // [RULE2]
    end
  end

  // ==========================================================
  // Short-fault retry timer
  // ==========================================================
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      retry_r <= '0;
    else if (!short_fault || retry_tick)
      retry_r <= '0;
    else
      retry_r <= retry_r + 32'd1;                        // [RULE4]
  end

  // ==========================================================
  // Sequencer state, step counter and interval timers
  // ==========================================================
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r  <= SSS_IDLE;
      step_r   <= STEP_RST;
      tick_r   <= '0;
      ss_cnt_r <= '0;
    end
    else if (restart || (short_fault && (retry_tick || retry_r == 0)))
    begin
      // Any restart source clears the ramp
      state_r  <= armed_r ? SSS_RAMP : SSS_WAIT;         // [RULE3] [RULE4]
      step_r   <= STEP_RST;                              // [RULE16]
      tick_r   <= '0;
      ss_cnt_r <= '0;
    end
    else
    begin
      unique case (state_r)
        SSS_IDLE, SSS_WAIT:
          if (rise)
            state_r <= SSS_RAMP;                         // [RULE2]
        SSS_RAMP:
        begin
          if (ss_cnt_r < SS_CYC)
            ss_cnt_r <= ss_cnt_r + 32'd1;
          if (dim_on | ext_active_r)
          begin
            tick_r <= step_tick ? '0 : tick_r + 32'd1;   // [RULE16]
            if (step_tick && step_r < 4'(SS_STEPS))
              step_r <= step_r + 4'd1;                   // [RULE13]
          end
          if (step_r == 4'(SS_STEPS))
            state_r <= SSS_RUN;
        end
        SSS_RUN:
          state_r <= SSS_RUN;
      endcase
    end
  end

  // ==========================================================
  // ON time extension
  // ==========================================================
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ext_active_r <= 1'b0;
      pulse_r      <= '0;
    end
    else
    begin
      pulse_r <= rise ? '0 : (dim_on ? pulse_r + 32'd1 : pulse_r);
      if (state_r != SSS_RAMP)
        ext_active_r <= 1'b0;
      else if (ext_active_r)
      begin
        if (sense_diff >= ext_thr_r)
          ext_active_r <= 1'b0;                          // [RULE8]
        else if (adj_en && adj_ref < EXT_FLOOR && ss_done)
          ext_active_r <= 1'b0;                          // [RULE11]
      end
      else if (fall && pulse_r < SS_CYC && sense_diff < ext_thr_r)
        ext_active_r <= 1'b1;                            // [RULE7] [RULE12]
    end
  end

  // ==========================================================
  // Registered outputs
  // ==========================================================
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ref_r       <= '0;
      ext_thr_r   <= EXT_FLOOR;
      gate_en_r   <= 1'b0;
      ss_busy_r   <= 1'b0;
      vloop_sel_r <= 1'b0;
    end
    else
    begin
      ref_r       <= (state_r == SSS_RUN) ? target : ramp_ref;
      ext_thr_r   <= ext_nxt;
      gate_en_r   <= (state_r != SSS_IDLE) & (dim_on | ext_active_r);
      ss_busy_r   <= (state_r == SSS_RAMP);
      // Current loop always on; voltage loop takes over at its ref
      vloop_sel_r <= vloop_en & vfb_at_ref;              // [RULE14] [RULE15]
    end
  end

endmodule : sss_channel

// [design/sss_top.sv]
/*
  Dual-channel soft-start sequencer top.
  Assumes asynchronous pin levels and digitised analog comparisons.
*/
// Contract
// [RULE1] Each channel runs its own independent soft-start sequence.
// [RULE2] Soft start arms on the first dimming rising edge or engine cycle.
// [RULE3] Soft start restarts at power-up, overvoltages, overtemp, undervolt.
// [RULE4] A short fault applies soft start and retriggers each retry period.
// [RULE5] Without adjustment the reference rises in exactly 15 steps.
// [RULE6] With adjustment the adjusted reference is reached early.
// [RULE7] Short dimming pulses with low sense voltage start an extension.
// [RULE8] Extension lasts until sense voltage reaches the threshold.
// [RULE9] Adjustment lowers the extension threshold but not below a floor.
// [RULE10] During the first 3 steps the threshold stays above the reference.
// [RULE11] If the adjusted reference is below the floor, extension ends at tss.
// [RULE12] An early-ended extension restarts next cycle when sense is low.
// [RULE13] Remaining steps advance only during later dimming ON times.
// [RULE14] Current loop is always on; voltage loop is optional.
// [RULE15] Voltage loop takes over once feedback reaches its reference.
// [RULE16] Steps come at equal intervals; restart clears the step counter.
module sss_top
  import sss_pkg::*;
#(
  parameter int unsigned SS_CYC    = SS_TIME_CYC,
  parameter int unsigned STEP_LEN  = STEP_CYC,
  parameter int unsigned RETRY_CYC = FAULT_RETRY_CYC
)(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [1:0]        dimming_input,
  input  wire logic [1:0]        ov_sense_high,
  input  wire logic [1:0]        ov_voltage_feedback,
  input  wire logic              overtemp,
  input  wire logic              internal_supply_uv,
  input  wire logic [1:0]        short_to_ground,
  input  wire logic [1:0]        adj_en,
  input  wire logic [2*REF_W-1:0] adj_ref,
  input  wire logic [2*REF_W-1:0] sense_diff,
  input  wire logic [1:0]        vloop_en,
  input  wire logic [1:0]        vfb_at_ref,
  output logic [2*REF_W-1:0]     ref_out,
  output logic [2*REF_W-1:0]     extension_threshold,
  output logic [1:0]             ext_active,
  output logic [1:0]             gate_drive_output,
  output logic [1:0]             ss_busy,
  output logic [1:0]             voltage_loop_sel
);

  localparam int unsigned NSYNC = 10;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] syn;
  logic             pwr_up_r;

  assign raw = {dimming_input, ov_sense_high, ov_voltage_feedback,
                overtemp, internal_supply_uv, short_to_ground};

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  sss_sync #(.W(NSYNC)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (raw),
    .q   (syn)
  );

  // Power-up pulse one cycle after reset release
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pwr_up_r <= 1'b1;
    else
      pwr_up_r <= 1'b0;                                  // [RULE3]
  end

  // ==========================================================
  // Independent channels
  // ==========================================================
  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    sss_channel #(
      .SS_CYC    (SS_CYC),
      .STEP_LEN  (STEP_LEN),
      .RETRY_CYC (RETRY_CYC)
    ) u_ch (                                             // [RULE1]
      .clk          (clk),
      .rst          (rst),
      .dim_on       (syn[8+c]),
      .restart      (pwr_up_r | syn[6+c] | syn[4+c] | syn[3] | syn[2]),
      .short_fault  (syn[c]),
      .adj_en       (adj_en[c]),
      .adj_ref      (adj_ref[c*REF_W +: REF_W]),
      .sense_diff   (sense_diff[c*REF_W +: REF_W]),
      .vloop_en     (vloop_en[c]),
      .vfb_at_ref   (vfb_at_ref[c]),
      .ref_r        (ref_out[c*REF_W +: REF_W]),
      .ext_thr_r    (extension_threshold[c*REF_W +: REF_W]),
      .ext_active_r (ext_active[c]),
      .gate_en_r    (gate_drive_output[c]),
      .ss_busy_r    (ss_busy[c]),
      .vloop_sel_r  (voltage_loop_sel[c])
    );
  end

endmodule : sss_top

// [sim/sss_top_monitor.sv]
/*
  Port checker for the soft-start sequencer top, channel 0 in focus.
  Assumes the bench keeps adjustment off except where it says so.
*/
module sss_top_monitor
  import sss_pkg::*;
#(
  parameter int unsigned STEP_LEN = STEP_CYC
)(
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                overtemp,
  input wire logic [1:0]          short_to_ground,
  input wire logic [1:0]          adj_en,
  input wire logic [1:0]          vloop_en,
  input wire logic [2*REF_W-1:0]  ref_out,
  input wire logic [2*REF_W-1:0]  extension_threshold,
  input wire logic [1:0]          ext_active,
  input wire logic [1:0]          ss_busy,
  input wire logic [1:0]          voltage_loop_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  // Channel 0 slices
  wire logic [9:0] r0 = ref_out[9:0];
  wire logic [9:0] t0 = extension_threshold[9:0];
  // ==========
  // Properties
  // ==========
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_ref_max;
    !adj_en[0] |-> r0 <= REF_FULL;
  endproperty
  a_ref_max: assert property (p_ref_max)
    else $error("reference above full scale");
  // Unadjusted ramp lands only on multiples of one fifteenth
  property p_grid;
    !adj_en[0] && !$past(adj_en[0], 3) |-> r0 % 20 == 0;
  endproperty
  a_grid: assert property (p_grid)
    else $error("reference off the step grid");
  property p_floor;
    t0 >= EXT_FLOOR;
  endproperty
  a_floor: assert property (p_floor)
    else $error("threshold below floor");
  property p_early;
    ss_busy[0] && !adj_en[0] && !$past(adj_en[0]) && r0 <= 60 |-> t0 > r0;
  endproperty
  a_early: assert property (p_early)
    else $error("threshold not above early reference");
  property p_restart;
    overtemp [*5] |-> ref_out == 20'h00000;
  endproperty
  a_restart: assert property (p_restart)
    else $error("reference kept during restart");
  property p_short;
    $rose(short_to_ground[0]) |-> ##[1:6] r0 == 10'h000;
  endproperty
  a_short: assert property (p_short)
    else $error("short fault did not restart ramp");
  // Steps are spaced; only a restart may cut a step short
  property p_hold;
    $changed(r0) && r0 != 0 && !adj_en[0]
      |=> ($stable(r0) || r0 == 10'h000) [*8];
  endproperty
  a_hold: assert property (p_hold)
    else $error("reference stepped too early");
  property p_vsel;
    (!vloop_en[0]) [*5] |-> !voltage_loop_sel[0];
  endproperty
  a_vsel: assert property (p_vsel)
    else $error("voltage loop selected while disabled");
  c_busy: cover property ($rose(ss_busy[0]));
  c_ext: cover property ($rose(ext_active[0]));
  c_vsel: cover property ($rose(voltage_loop_sel[0]));
endmodule : sss_top_monitor

bind sss_top sss_top_monitor #(.STEP_LEN(STEP_LEN)) i_sss_top_monitor (
  .clk(clk), .rst(rst), .overtemp(overtemp),
  .short_to_ground(short_to_ground), .adj_en(adj_en),
  .vloop_en(vloop_en), .ref_out(ref_out),
  .extension_threshold(extension_threshold), .ext_active(ext_active),
  .ss_busy(ss_busy), .voltage_loop_sel(voltage_loop_sel));

// [sim/sss_plant.sv]
/*
  Dimming source and power stage model for one channel.
  Assumes a 40 cycle dimming period; sense follows the gate.
*/
module sss_plant
  import sss_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire logic [7:0]       on_len,
  input  wire logic             gate,
  output logic                  dim,
  output logic [REF_W-1:0]      sense
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ph_r;
  // Pulse source; slow stage so short pulses leave sense low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ph_r  <= 8'h00;
      dim   <= 1'b0;
      sense <= 10'h000;
    end
    else
    begin
      ph_r  <= (ph_r == 8'h27) ? 8'h00 : ph_r + 8'h01;
      dim   <= run && (ph_r < on_len);
      if (gate && sense != 10'h3FF)
        sense <= sense + 10'h001;
      else if (!gate && sense != 10'h000)
        sense <= sense - 10'h001;
    end
  end
endmodule : sss_plant

// [sim/sss_top_bench.sv]
/*
  Self-checking bench for the soft-start sequencer, channel 0 active.
  Assumes shortened timing; channel 1 is never armed.
*/
module sss_top_bench
  import sss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, run, dim, d1, hold_low;
  logic [7:0]  on_len;
  logic [4:0]  rs;
  logic [1:0]  adj_en, vloop_en, vfb_at_ref, gate, ext, busy, vsel;
  logic [9:0]  sense, ar;
  logic [19:0] ref_o, thr;
  int          mismatches, compares;
  sss_top #(.SS_CYC(150), .STEP_LEN(10), .RETRY_CYC(300)) i_sss_top (
    .clk(clk), .rst(rst), .dimming_input({d1, dim}),
    .ov_sense_high({1'b0, rs[0]}), .ov_voltage_feedback({1'b0, rs[1]}),
    .overtemp(rs[2]), .internal_supply_uv(rs[3]),
    .short_to_ground({1'b0, rs[4]}), .adj_en(adj_en),
    // hold_low pins channel 0's sensed level at zero
    .adj_ref({ar, ar}), .sense_diff({sense, hold_low ? 10'h000 : sense}),
    .vloop_en(vloop_en), .vfb_at_ref(vfb_at_ref), .ref_out(ref_o),
    .extension_threshold(thr), .ext_active(ext),
    .gate_drive_output(gate), .ss_busy(busy), .voltage_loop_sel(vsel));
  sss_plant i_sss_plant (.clk(clk), .rst(rst), .run(run),
    .on_len(on_len), .gate(gate[0]), .dim(dim), .sense(sense));
  // ==========
  // Helpers
  // ==========
  task chk(input bit ok, input string m);
    compares++;
    if (!ok)
    begin
      mismatches++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // ==========
  // Scenarios
  // ==========
  task t_ramp;
    int n, t, bad;
    logic [9:0] p;
    n = 0; t = 0; bad = 0; p = 10'h000;
    run = 1'b1;
    cyc(8);
    chk(busy === 2'b01 && gate === 2'b01, "arming");
    repeat (400)
    begin
      cyc(1);
      t++;
      if (ref_o[9:0] !== p)
      begin
        n++;
        if (n > 1 && t != 10) bad++;
        t = 0;
        p = ref_o[9:0];
      end
    end
    chk(n == 15 && p === REF_FULL, "step count");
    chk(bad == 0, "step spacing");
  endtask : t_ramp
  // Voltage loop only takes over once enabled and at its reference
  task t_vloop;
    vloop_en = 2'b01;
    cyc(6);
    chk(vsel === 2'b00, "voltage loop too early");
    vfb_at_ref = 2'b01;
    cyc(6);
    chk(vsel === 2'b01, "voltage loop take-over");
    vloop_en = 2'b00;
    cyc(6);
    chk(vsel === 2'b00, "voltage loop off");
    vfb_at_ref = 2'b00;
  endtask : t_vloop
  // Each restart source in turn; short fault held past one retry
  task t_restart;
    int z;
    for (int i = 0; i < 5; i++)
    begin
      rs = 5'h01 << i;
      cyc(7);
      chk(ref_o[9:0] === 10'h000, "restart clear");
      z = 0;
      // Latch: ramp seen rising, then cleared again by the retry
      repeat ((i == 4) ? 400 : 0)
      begin
        cyc(1);
        if (z == 0 && ref_o[9:0] !== 10'h000) z = -1;
        else if (z == -1 && ref_o[9:0] === 10'h000) z = 1;
      end
      if (i == 4) chk(z == 1, "no retry");
      rs = 5'h00;
      cyc(300);
      chk(ref_o[9:0] === REF_FULL, "ramp after restart");
    end
  endtask : t_restart
  task t_ext;
    int k;
    logic [9:0] p;
    on_len = 8'h03;
    rs = 5'h04; cyc(3); rs = 5'h00;
    // Sense starts saturated and needs about 25 short periods to sink
    for (k = 0; k < 1500 && ext[0] !== 1'b1; k++) cyc(1);
    chk(ext[0] === 1'b1, "no extension");
    for (k = 0; k < 1000 && ext[0] === 1'b1; k++)
    begin
      p = sense;
      cyc(1);
    end
    chk(ext[0] === 1'b0 && p + 2 >= thr[9:0], "early end");
    for (k = 0; k < 200 && ext[0] !== 1'b1; k++) cyc(1);
    chk(ext[0] === 1'b1, "no retrigger");
  endtask : t_ext
  // Adjusted target below the floor; restart released just after a
  // pulse so the first extension starts well inside tss
  task t_adj;
    int k;
    rs = 5'h04;
    cyc(3);
    adj_en = 2'b01;
    ar = 10'h014;
    cyc(3);
    chk(thr[9:0] === EXT_FLOOR, "threshold floor");
    for (k = 0; k < 50 && dim !== 1'b1; k++) cyc(1);
    cyc(8);
    rs = 5'h00;
    hold_low = 1'b1;
    for (k = 0; k < 100 && ext[0] !== 1'b1; k++) cyc(1);
    chk(ext[0] === 1'b1, "no extension on low sense");
    // Sense never reaches the floor, so only tss can end it
    for (k = 0; k < 300 && ext[0] === 1'b1; k++) cyc(1);
    chk(ext[0] === 1'b0 && busy === 2'b01, "ext after tss");
    chk(ref_o[9:0] === ar, "adjusted target");
    hold_low = 1'b0;
  endtask : t_adj
  // ==========
  // Main flow
  // ==========
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    #1ms;
    mismatches++;
    report_and_stop();
  end
  initial
  begin
    {rst, run, d1, rs, adj_en, vloop_en, vfb_at_ref, ar, hold_low} = '0;
    rst = 1'b1;
    on_len = 8'h28;
    cyc(10);
    rst = 1'b0;
    cyc(20);
    chk(busy === 2'b00 && ref_o === 20'h0, "idle");
    t_ramp();
    t_vloop();
    t_restart();
    t_ext();
    t_adj();
    report_and_stop();
  end
endmodule : sss_top_bench
